// ---- rscs_defs.svh ----
`ifndef RSCS_DEFS_SVH
`define RSCS_DEFS_SVH

// Pin and field geometry.
`define RSCS_GPIO_NUM 16
`define RSCS_CLK_OUT_NUM 12
`define RSCS_SEL_BASE_W 4
`define RSCS_PIN_IFACE_SEL 9
`define RSCS_PIN_MUST_HIGH 8

// Pin function masks used by parts whose factory block is unprogrammed.
`define RSCS_DEF_SEL_MASK 16'h000F
`define RSCS_DEF_ADDR_MASK 16'h0000
`define RSCS_DEF_EEDIS_MASK 16'h0000

// Register reset values: everything neutral, outputs off, pins as inputs.
`define RSCS_RST_IFACE_I2C 1'h1
`define RSCS_RST_ADDR_BIT2 1'h0
`define RSCS_RST_EEP_SEARCH 1'h1
`define RSCS_RST_CLK_OUT_EN 12'h000
`define RSCS_RST_GPIO_INPUT 16'hFFFF

// Field selectors on the two register write ports.
`define RSCS_FLD_IFACE 3'h0
`define RSCS_FLD_ADDR_BIT2 3'h1
`define RSCS_FLD_EEP_SEARCH 3'h2
`define RSCS_FLD_CLK_OUT_EN 3'h3
`define RSCS_FLD_GPIO_INPUT 3'h4

`endif

// ---- rscs_pkg.sv ----
package rscs_pkg;

  typedef enum logic [3:0] {
    RSCS_ST_HOLD,
    RSCS_ST_CAPTURE,
    RSCS_ST_OTP_LOAD,
    RSCS_ST_EEP_LOAD,
    RSCS_ST_REG_EN,
    RSCS_ST_CLK_EN,
    RSCS_ST_PLL_CAL,
    RSCS_ST_PLL_LOCK,
    RSCS_ST_READY
  } rscs_state_t;

endpackage : rscs_pkg

// ---- rscs_sync.sv ----
`include "rscs_defs.svh"

// Two-flop synchroniser for pins arriving from outside the clock domain.
module rscs_sync #(
  parameter int WIDTH = 1
) (
  input wire logic i_ref_clk, // System clock.
  input wire logic i_rstn, // Synchronous reset, active low.
  input wire logic [WIDTH-1:0] i_async, // Raw pin levels.
  input wire logic [WIDTH-1:0] i_rst_val, // Value held while in reset.
  output logic [WIDTH-1:0] o_sync // Synchronised levels.
);

  logic [WIDTH-1:0] stage1;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      stage1 <= i_rst_val;
      o_sync <= i_rst_val;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end

endmodule : rscs_sync

// ---- rscs_strap_config.sv ----
// What this block does
// - Capture every GPIO level at reset release.
// - Pin 9 low selects SPI, high I2C.
// - Strap-derived register values stay software writable.
// - No address pin assigned gives bit zero.
// - Address pin ignored when SPI selected.
// - Several address pins: highest index wins.
// - Loaded configuration may overwrite strap values.
// - EEPROM-disable pin high skips EEPROM reads.
// - No disable pin: EEPROM search is attempted in I2C mode.
// - Several disable pins are ORed together.
// - No selection pins: pins 3..0 give index.
// - Undriven pulled-up default selection pins 3..0 select fifteen.
// - Selection pins ordered by index, lowest LSB.
// - Fewer than four pins: upper bits zero.
// - More than four pins widen the index.
// - Factory block assigns pin functions, else defaults.
// - Defaults: clock outputs off, GPIOs inputs.
// - Four sources: pins, OTP, EEPROM, defaults.
// - Load, regulators, clocks, PLL calibrate, lock.
// - OTP checksum failure shuts the load window; earlier writes stay.
// - SPI mode skips the EEPROM search.
`include "rscs_defs.svh"

module rscs_strap_config (
  input wire logic i_ref_clk, // System clock, 100 MHz.
  input wire logic i_rstn, // Synchronous reset, active low.
  input wire logic i_master_reset_in_low, // Master reset pin, active low, asynchronous.
  input wire logic [`RSCS_GPIO_NUM-1:0] i_gpio_pin, // GPIO pin levels, asynchronous.
  input wire logic i_info_programmed, // Factory information block is programmed.
  input wire logic [`RSCS_GPIO_NUM-1:0] i_info_sel_mask, // Pins assigned to configuration select.
  input wire logic [`RSCS_GPIO_NUM-1:0] i_info_addr_mask, // Pins assigned to address bit two.
  input wire logic [`RSCS_GPIO_NUM-1:0] i_info_eedis_mask, // Pins assigned to EEPROM disable.
  input wire logic i_otp_done, // OTP load step finished, pulse.
  input wire logic i_otp_cksum_err, // OTP image failed checksum, with done.
  input wire logic i_eep_done, // EEPROM step finished, pulse.
  input wire logic i_reg_done, // Regulators up, pulse.
  input wire logic i_clk_done, // Internal clocks running, pulse.
  input wire logic i_cal_done, // PLL calibration finished, pulse.
  input wire logic i_lock_done, // PLL locked to crystal, pulse.
  input wire logic i_cfg_wr_en, // Loaded configuration write strobe.
  input wire logic [2:0] i_cfg_wr_fld, // Loaded configuration field select.
  input wire logic [15:0] i_cfg_wr_data, // Loaded configuration write data.
  input wire logic i_ser_wr_en, // Serial port write strobe.
  input wire logic [2:0] i_ser_wr_fld, // Serial port field select.
  input wire logic [15:0] i_ser_wr_data, // Serial port write data.
  output logic o_captured, // Strap samples are valid.
  output logic [`RSCS_GPIO_NUM-1:0] o_strap_pins, // Captured pin levels.
  output logic o_strap_fault, // Pin 8 was low at capture.
  output logic [`RSCS_GPIO_NUM-1:0] o_cfg_index, // Stored configuration index.
  output logic [4:0] o_cfg_index_bits, // Significant bits of the index.
  output logic o_eep_disable, // EEPROM access disabled by strap.
  output logic o_iface_i2c, // Main serial port is I2C.
  output logic o_slave_addr_bit_two, // I2C slave base address bit two.
  output logic o_eep_search_en, // EEPROM search will run.
  output logic [`RSCS_CLK_OUT_NUM-1:0] o_clk_out_en, // Clock output enables.
  output logic [`RSCS_GPIO_NUM-1:0] o_gpio_is_input, // GPIO input-mode flags.
  output logic o_otp_load_req, // Request OTP configuration load.
  output logic o_otp_apply, // OTP data may be written to registers.
  output logic o_eep_load_req, // Request EEPROM search and load.
  output logic o_reg_en_req, // Enable internal regulators.
  output logic o_clk_en_req, // Start internal clocks.
  output logic o_pll_cal_req, // Calibrate analog PLL.
  output logic o_pll_lock_req, // Lock analog PLL to crystal.
  output logic o_ready // Start-up sequence complete.
);

  // Packs the masked pins in ascending index order, lowest index in bit 0.
  function automatic logic [`RSCS_GPIO_NUM-1:0] pack_pins(
    input logic [`RSCS_GPIO_NUM-1:0] pins,
    input logic [`RSCS_GPIO_NUM-1:0] mask
  );
    logic [`RSCS_GPIO_NUM-1:0] res;
    int pos;
    res = '0;
    pos = 0;
    for (int k = 0; k < `RSCS_GPIO_NUM; k++) begin
      if (mask[k]) begin
        res[pos[3:0]] = pins[k];
        pos = pos + 1;
      end
    end
    return res;
  endfunction : pack_pins

  // Number of pins set in a function mask.
  function automatic logic [4:0] count_pins(input logic [`RSCS_GPIO_NUM-1:0] mask);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < `RSCS_GPIO_NUM; k++) begin
      n = n + {4'h0, mask[k]};
    end
    return n;
  endfunction : count_pins

  // Level of the highest-index pin in the mask, zero when the mask is empty.
  function automatic logic top_pin(
    input logic [`RSCS_GPIO_NUM-1:0] pins,
    input logic [`RSCS_GPIO_NUM-1:0] mask
  );
    logic v;
    v = 1'b0;
    for (int k = 0; k < `RSCS_GPIO_NUM; k++) begin
      if (mask[k]) begin
        v = pins[k];
      end
    end
    return v;
  endfunction : top_pin

  logic mr_sync;
  logic mr_prev;
  logic [`RSCS_GPIO_NUM-1:0] gpio_sync;
  logic mr_rise;
  logic mr_active;
  rscs_pkg::rscs_state_t state;
  rscs_pkg::rscs_state_t next_state;
  logic [`RSCS_GPIO_NUM-1:0] sel_mask;
  logic [`RSCS_GPIO_NUM-1:0] addr_mask;
  logic [`RSCS_GPIO_NUM-1:0] eedis_mask;
  logic [4:0] sel_count;
  logic strap_i2c;
  logic strap_addr;
  logic strap_eedis;
  logic cfg_hit;
  logic ser_hit;

  rscs_sync #(
    .WIDTH(`RSCS_GPIO_NUM + 1)
  ) u_pin_sync (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_async({i_master_reset_in_low, i_gpio_pin}),
    .i_rst_val({1'b1, `RSCS_RST_GPIO_INPUT}),
    .o_sync({mr_sync, gpio_sync})
  );

  assign mr_active = !mr_sync;
  assign mr_rise = mr_sync && !mr_prev;

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      mr_prev <= 1'b1;
    end else begin
      mr_prev <= mr_sync;
    end
  end

  // Pin function assignment: factory block if programmed, defaults otherwise.
  always_comb begin
    if (i_info_programmed) begin
      addr_mask = i_info_addr_mask;
      eedis_mask = i_info_eedis_mask;
      if (i_info_sel_mask == '0) begin
        sel_mask = `RSCS_DEF_SEL_MASK;
      end else begin
        sel_mask = i_info_sel_mask;
      end
    end else begin
      sel_mask = `RSCS_DEF_SEL_MASK;
      addr_mask = `RSCS_DEF_ADDR_MASK;
      eedis_mask = `RSCS_DEF_EEDIS_MASK;
    end
  end

  assign sel_count = count_pins(sel_mask);
  assign strap_i2c = gpio_sync[`RSCS_PIN_IFACE_SEL];
  assign strap_addr = strap_i2c ? top_pin(gpio_sync, addr_mask) : 1'b0;
  assign strap_eedis = |(gpio_sync & eedis_mask);

  // Strap capture; the captured copy is frozen until master reset returns.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn) begin
      o_captured <= 1'b0;
      o_strap_pins <= '0;
      o_strap_fault <= 1'b0;
      o_cfg_index <= '0;
      o_cfg_index_bits <= 5'h00;
      o_eep_disable <= 1'b0;
    end else if (mr_active) begin
      o_captured <= 1'b0;
    end else if (mr_rise) begin
      o_captured <= 1'b1;
      o_strap_pins <= gpio_sync;
      o_strap_fault <= !gpio_sync[`RSCS_PIN_MUST_HIGH];
      // Unused upper bits come out as zero, so an all-high default picks 15.
      o_cfg_index <= pack_pins(gpio_sync, sel_mask);
      o_cfg_index_bits <= (sel_count < 5'(`RSCS_SEL_BASE_W)) ? 5'(`RSCS_SEL_BASE_W) : sel_count;
      o_eep_disable <= strap_eedis;
    end
  end

  assign cfg_hit = i_cfg_wr_en && o_otp_apply;
  assign ser_hit = i_ser_wr_en && (state == rscs_pkg::RSCS_ST_READY);

  // Interface select and address bit: strap first, then loaded data, then serial writes.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || mr_active) begin
      o_iface_i2c <= `RSCS_RST_IFACE_I2C;
      o_slave_addr_bit_two <= `RSCS_RST_ADDR_BIT2;
    end else if (mr_rise) begin
      o_iface_i2c <= strap_i2c;
      o_slave_addr_bit_two <= strap_addr;
    end else if (ser_hit && i_ser_wr_fld == `RSCS_FLD_IFACE) begin
      o_iface_i2c <= i_ser_wr_data[0];
    end else if (ser_hit && i_ser_wr_fld == `RSCS_FLD_ADDR_BIT2) begin
      o_slave_addr_bit_two <= i_ser_wr_data[0];
    end else if (cfg_hit && i_cfg_wr_fld == `RSCS_FLD_IFACE) begin
      o_iface_i2c <= i_cfg_wr_data[0];
    end else if (cfg_hit && i_cfg_wr_fld == `RSCS_FLD_ADDR_BIT2) begin
      o_slave_addr_bit_two <= i_cfg_wr_data[0];
    end
  end

  // EEPROM search enable follows the strap and the chosen interface.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || mr_active) begin
      o_eep_search_en <= `RSCS_RST_EEP_SEARCH;
    end else if (mr_rise) begin
      o_eep_search_en <= !strap_eedis && strap_i2c;
    end else if (ser_hit && i_ser_wr_fld == `RSCS_FLD_EEP_SEARCH) begin
      o_eep_search_en <= i_ser_wr_data[0];
    end else if (cfg_hit && i_cfg_wr_fld == `RSCS_FLD_EEP_SEARCH) begin
      o_eep_search_en <= i_cfg_wr_data[0];
    end
  end

  // Neutral register defaults until configuration data arrives.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || mr_active) begin
      o_clk_out_en <= `RSCS_RST_CLK_OUT_EN;
      o_gpio_is_input <= `RSCS_RST_GPIO_INPUT;
    end else if (ser_hit && i_ser_wr_fld == `RSCS_FLD_CLK_OUT_EN) begin
      o_clk_out_en <= i_ser_wr_data[`RSCS_CLK_OUT_NUM-1:0];
    end else if (ser_hit && i_ser_wr_fld == `RSCS_FLD_GPIO_INPUT) begin
      o_gpio_is_input <= i_ser_wr_data;
    end else if (cfg_hit && i_cfg_wr_fld == `RSCS_FLD_CLK_OUT_EN) begin
      o_clk_out_en <= i_cfg_wr_data[`RSCS_CLK_OUT_NUM-1:0];
    end else if (cfg_hit && i_cfg_wr_fld == `RSCS_FLD_GPIO_INPUT) begin
      o_gpio_is_input <= i_cfg_wr_data;
    end
  end

  // Loaded data reach the registers while a load step runs and for one cycle after it, unless an OTP checksum fault shut the window.
  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || mr_active) begin
      o_otp_apply <= 1'b0;
    end else if (state == rscs_pkg::RSCS_ST_OTP_LOAD && i_otp_cksum_err) begin
      // A checksum fault must shut the window even when the EEPROM step follows at once.
      o_otp_apply <= 1'b0;
    end else if (next_state == rscs_pkg::RSCS_ST_OTP_LOAD && state != rscs_pkg::RSCS_ST_OTP_LOAD) begin
      o_otp_apply <= 1'b1;
    end else if (next_state == rscs_pkg::RSCS_ST_EEP_LOAD && state != rscs_pkg::RSCS_ST_EEP_LOAD) begin
      o_otp_apply <= 1'b1;
    end else if (state != rscs_pkg::RSCS_ST_OTP_LOAD && state != rscs_pkg::RSCS_ST_EEP_LOAD) begin
      o_otp_apply <= 1'b0;
    end
  end

  // Start-up sequence after the strap capture.
  always_comb begin
    next_state = state;
    case (state)
      rscs_pkg::RSCS_ST_HOLD: begin
        if (mr_rise) begin
          next_state = rscs_pkg::RSCS_ST_CAPTURE;
        end
      end
      rscs_pkg::RSCS_ST_CAPTURE: begin
        next_state = rscs_pkg::RSCS_ST_OTP_LOAD;
      end
      rscs_pkg::RSCS_ST_OTP_LOAD: begin
        if (i_otp_done) begin
          if (o_eep_search_en && !o_eep_disable && o_iface_i2c) begin
            next_state = rscs_pkg::RSCS_ST_EEP_LOAD;
          end else begin
            next_state = rscs_pkg::RSCS_ST_REG_EN;
          end
        end
      end
      rscs_pkg::RSCS_ST_EEP_LOAD: begin
        if (i_eep_done) begin
          next_state = rscs_pkg::RSCS_ST_REG_EN;
        end
      end
      rscs_pkg::RSCS_ST_REG_EN: begin
        if (i_reg_done) begin
          next_state = rscs_pkg::RSCS_ST_CLK_EN;
        end
      end
      rscs_pkg::RSCS_ST_CLK_EN: begin
        if (i_clk_done) begin
          next_state = rscs_pkg::RSCS_ST_PLL_CAL;
        end
      end
      rscs_pkg::RSCS_ST_PLL_CAL: begin
        if (i_cal_done) begin
          next_state = rscs_pkg::RSCS_ST_PLL_LOCK;
        end
      end
      rscs_pkg::RSCS_ST_PLL_LOCK: begin
        if (i_lock_done) begin
          next_state = rscs_pkg::RSCS_ST_READY;
        end
      end
      rscs_pkg::RSCS_ST_READY: begin
        next_state = rscs_pkg::RSCS_ST_READY;
      end
      default: begin
        next_state = rscs_pkg::RSCS_ST_HOLD;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_rstn || mr_active) begin
      state <= rscs_pkg::RSCS_ST_HOLD;
    end else begin
      state <= next_state;
    end
  end

  // Step requests are levels held for the whole of their step.
  assign o_otp_load_req = (state == rscs_pkg::RSCS_ST_OTP_LOAD);
  assign o_eep_load_req = (state == rscs_pkg::RSCS_ST_EEP_LOAD);
  assign o_reg_en_req = (state == rscs_pkg::RSCS_ST_REG_EN);
  assign o_clk_en_req = (state == rscs_pkg::RSCS_ST_CLK_EN);
  assign o_pll_cal_req = (state == rscs_pkg::RSCS_ST_PLL_CAL);
  assign o_pll_lock_req = (state == rscs_pkg::RSCS_ST_PLL_LOCK);
  assign o_ready = (state == rscs_pkg::RSCS_ST_READY);

endmodule : rscs_strap_config

// ---- rscs_strap_config_props.sv ----
`include "rscs_defs.svh"

module rscs_strap_config_props (
  input wire logic i_ref_clk, // Clock.
  input wire logic i_rstn, // Reset, active low.
  input wire logic i_lock_done, // Lock step done.
  input wire logic i_ser_wr_en, // Serial write strobe.
  input wire logic [2:0] i_ser_wr_fld, // Serial field.
  input wire logic [15:0] i_ser_wr_data, // Serial data.
  input wire logic i_otp_cksum_err, // Checksum fault.
  input wire logic o_captured, // Samples valid.
  input wire logic [`RSCS_GPIO_NUM-1:0] o_strap_pins, // Captured pins.
  input wire logic [`RSCS_GPIO_NUM-1:0] o_cfg_index, // Index.
  input wire logic [4:0] o_cfg_index_bits, // Index width.
  input wire logic o_eep_disable, // Strap disable.
  input wire logic o_iface_i2c, // I2C selected.
  input wire logic o_slave_addr_bit_two, // Address bit two.
  input wire logic o_eep_search_en, // Search enabled.
  input wire logic [`RSCS_CLK_OUT_NUM-1:0] o_clk_out_en, // Clock enables.
  input wire logic [`RSCS_GPIO_NUM-1:0] o_gpio_is_input, // Input flags.
  input wire logic o_otp_load_req, // OTP step.
  input wire logic o_otp_apply, // Loader window.
  input wire logic o_pll_lock_req, // Lock step.
  input wire logic o_ready // Sequence done.
);
  logic [`RSCS_CLK_OUT_NUM-1:0] last_clk_data;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  always_ff @(posedge i_ref_clk) begin
    last_clk_data <= i_ser_wr_data[`RSCS_CLK_OUT_NUM-1:0];
  end

  chk_iface_strap: assert property ($rose(o_captured) |-> o_iface_i2c == o_strap_pins[`RSCS_PIN_IFACE_SEL])
    else $error("interface choice differs from captured pin");
  chk_spi_addr: assert property ($rose(o_captured) && !o_iface_i2c |-> !o_slave_addr_bit_two)
    else $error("address bit set in SPI mode");
  chk_search_en: assert property ($rose(o_captured) |-> o_eep_search_en == (!o_eep_disable && o_iface_i2c))
    else $error("search enable wrong at capture");
  chk_index_width: assert property ($rose(o_captured) |-> o_cfg_index_bits >= 5'h04)
    else $error("index narrower than four bits");
  chk_strap_hold: assert property (o_captured && $past(o_captured) |-> $stable(o_strap_pins) && $stable(o_cfg_index))
    else $error("captured values moved");
  chk_reg_defaults: assert property (!o_captured && $past(!o_captured) |->
    o_clk_out_en == `RSCS_RST_CLK_OUT_EN && o_gpio_is_input == `RSCS_RST_GPIO_INPUT)
    else $error("defaults wrong before capture");
  chk_otp_first: assert property ($rose(o_captured) |=> o_otp_load_req && o_otp_apply)
    else $error("OTP step did not follow capture");
  chk_lock_ready: assert property (o_pll_lock_req && i_lock_done |=> o_ready)
    else $error("ready missing after lock");
  chk_ser_write: assert property (o_ready && i_ser_wr_en && i_ser_wr_fld == `RSCS_FLD_CLK_OUT_EN |=>
    o_clk_out_en == last_clk_data)
    else $error("serial write not applied");
  chk_cksum_close: assert property (o_otp_apply && i_otp_cksum_err |-> ##[1:2] !o_otp_apply)
    else $error("loader window open after checksum fault");

  cover property ($rose(o_captured) && !o_iface_i2c);
  cover property (o_otp_apply && i_otp_cksum_err);
  cover property ($rose(o_ready));
endmodule : rscs_strap_config_props

bind rscs_strap_config rscs_strap_config_props u_props (.*);

// ---- rscs_strap_model.sv ----
module rscs_strap_model (
  input wire logic i_hold_low, // Controller holds master reset.
  input wire logic [15:0] i_drive_en, // Pins driven by controller.
  input wire logic [15:0] i_drive_val, // Levels on driven pins.
  output logic o_master_reset_in_low, // Master reset pin.
  output logic [15:0] o_gpio_pin // Pin levels at the device.
);
  assign o_master_reset_in_low = !i_hold_low;
  // Undriven pins float up through the internal pull-ups, so pin 8 idles high.
  assign o_gpio_pin = (i_drive_en & i_drive_val) | ~i_drive_en;
endmodule : rscs_strap_model

// ---- tb_rscs_strap_config.sv ----
`include "rscs_defs.svh"
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin err_total++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end

module tb_rscs_strap_config;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic prog;
    logic [15:0] sel, adr, eed, den, dval, idx;
    logic [4:0] bits;
    logic i2c, a2, dis, srch, flt;
  } rscs_row_t;
  logic i_ref_clk, i_rstn, i_master_reset_in_low, i_info_programmed, i_otp_cksum_err;
  logic i_otp_done, i_eep_done, i_reg_done, i_clk_done, i_cal_done, i_lock_done, i_cfg_wr_en, i_ser_wr_en;
  logic [15:0] i_gpio_pin, i_info_sel_mask, i_info_addr_mask, i_info_eedis_mask, i_cfg_wr_data, i_ser_wr_data;
  logic [2:0] i_cfg_wr_fld, i_ser_wr_fld;
  logic o_captured, o_strap_fault, o_eep_disable, o_iface_i2c, o_slave_addr_bit_two, o_eep_search_en;
  logic [15:0] o_strap_pins, o_cfg_index, o_gpio_is_input;
  logic [4:0] o_cfg_index_bits;
  logic [11:0] o_clk_out_en;
  logic o_otp_load_req, o_otp_apply, o_eep_load_req, o_reg_en_req, o_clk_en_req, o_pll_cal_req, o_pll_lock_req;
  logic o_ready, mr_hold, otp_auto, otp_kick;
  logic [15:0] drv_en, drv_val;
  int err_total, compares;
  rscs_row_t rows [6] = '{
    '{0, 16'h00F0, 16'h0400, 16'h0800, 16'h00F0, 16'h0000, 16'h000F, 4, 1, 0, 0, 1, 0},
    '{0, 16'h0000, 16'h0000, 16'h0000, 16'h020F, 16'h0005, 16'h0005, 4, 0, 0, 0, 0, 0},
    '{1, 16'h0864, 16'h0090, 16'h0000, 16'h08F4, 16'h0054, 16'h0005, 4, 1, 0, 0, 1, 0},
    '{1, 16'h0003, 16'h0090, 16'h3000, 16'h1090, 16'h0080, 16'h0003, 4, 1, 1, 1, 0, 0},
    '{1, 16'h003F, 16'h0020, 16'h0000, 16'h023F, 16'h002A, 16'h002A, 6, 0, 0, 0, 0, 0},
    '{1, 16'h0000, 16'h0000, 16'h0000, 16'h010F, 16'h000A, 16'h000A, 4, 1, 0, 0, 1, 1}
  };

  rscs_strap_model u_straps (.i_hold_low(mr_hold), .i_drive_en(drv_en), .i_drive_val(drv_val),
    .o_master_reset_in_low(i_master_reset_in_low), .o_gpio_pin(i_gpio_pin));
  rscs_strap_config dut (.*);

  initial begin
    i_ref_clk = 1'b0;
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // Each step's done answers its request half a cycle later, as one pulse; OTP done follows otp_kick instead while otp_auto is low.
  always @(negedge i_ref_clk) begin
    i_otp_done <= otp_auto ? (o_otp_load_req && !i_otp_done) : otp_kick;
    i_otp_cksum_err <= otp_kick;
    i_eep_done <= o_eep_load_req && !i_eep_done;
    i_reg_done <= o_reg_en_req && !i_reg_done;
    i_clk_done <= o_clk_en_req && !i_clk_done;
    i_cal_done <= o_pll_cal_req && !i_cal_done;
    i_lock_done <= o_pll_lock_req && !i_lock_done;
  end

  task stop_test;
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  task restrap(input int r);
    mr_hold = 1'b1;
    i_info_programmed = rows[r].prog;
    i_info_sel_mask = rows[r].sel;
    i_info_addr_mask = rows[r].adr;
    i_info_eedis_mask = rows[r].eed;
    drv_en = rows[r].den;
    drv_val = rows[r].dval;
    repeat (5) @(negedge i_ref_clk);
    mr_hold = 1'b0;
  endtask : restrap

  task settle(input bit to_ready);
    for (int k = 0; k < 60 && !(to_ready ? o_ready === 1'b1 : o_otp_apply === 1'b1); k++) @(negedge i_ref_clk);
    `CHK(to_ready ? o_ready : o_otp_apply, 1'b1)
  endtask : settle

  task wr(input bit ser, input logic [2:0] f, input logic [15:0] d);
    {i_ser_wr_fld, i_ser_wr_data, i_ser_wr_en} = {f, d, ser};
    {i_cfg_wr_fld, i_cfg_wr_data, i_cfg_wr_en} = {f, d, !ser};
    @(negedge i_ref_clk);
    {i_ser_wr_en, i_cfg_wr_en} = 2'h0;
    @(negedge i_ref_clk);
  endtask : wr

  initial begin
    repeat (3000) @(posedge i_ref_clk);
    err_total++;
    stop_test();
  end

  initial begin
    {i_rstn, i_info_programmed, i_cfg_wr_en, i_ser_wr_en, otp_kick} = '0;
    {i_info_sel_mask, i_info_addr_mask, i_info_eedis_mask, i_cfg_wr_data, i_ser_wr_data} = '0;
    {i_cfg_wr_fld, i_ser_wr_fld, drv_en, drv_val} = '0;
    mr_hold = 1'b1;
    otp_auto = 1'b1;
    repeat (6) @(negedge i_ref_clk);
    i_rstn = 1'b1;
    `CHK(o_gpio_is_input, 16'hFFFF)
    `CHK(o_clk_out_en, 12'h000)
    for (int r = 0; r < 6; r++) begin
      restrap(r);
      settle(1'b1);
      `CHK(o_cfg_index, rows[r].idx)
      `CHK(o_cfg_index_bits, rows[r].bits)
      `CHK(o_iface_i2c, rows[r].i2c)
      `CHK(o_slave_addr_bit_two, rows[r].a2)
      `CHK(o_eep_disable, rows[r].dis)
      `CHK(o_eep_search_en, rows[r].srch)
      `CHK(o_strap_fault, rows[r].flt)
      $display("row %0d done", r);
    end
    drv_en = 16'hFFFF;
    drv_val = 16'h0000;
    repeat (4) @(negedge i_ref_clk);
    `CHK(o_cfg_index, 16'h000A)
    `CHK(o_strap_pins[`RSCS_PIN_IFACE_SEL], 1'b1)
    wr(1'b1, `RSCS_FLD_CLK_OUT_EN, 16'h0ABC);
    `CHK(o_clk_out_en, 12'hABC)
    wr(1'b1, `RSCS_FLD_IFACE, 16'h0000);
    `CHK(o_iface_i2c, 1'b0)
    wr(1'b1, `RSCS_FLD_GPIO_INPUT, 16'h1234);
    `CHK(o_gpio_is_input, 16'h1234)
    $display("serial test done");
    otp_auto = 1'b0;
    restrap(0);
    settle(1'b0);
    `CHK(o_clk_out_en, 12'h000)
    `CHK(o_gpio_is_input, 16'hFFFF)
    wr(1'b1, `RSCS_FLD_GPIO_INPUT, 16'h0000);
    `CHK(o_gpio_is_input, 16'hFFFF)
    wr(1'b0, `RSCS_FLD_ADDR_BIT2, 16'h0001);
    `CHK(o_slave_addr_bit_two, 1'b1)
    otp_kick <= 1'b1;
    @(negedge i_ref_clk);
    otp_kick <= 1'b0;
    repeat (3) @(negedge i_ref_clk);
    wr(1'b0, `RSCS_FLD_CLK_OUT_EN, 16'h0FFF);
    `CHK(o_clk_out_en, 12'h000)
    `CHK(o_otp_apply, 1'b0)
    otp_auto = 1'b1;
    settle(1'b1);
    $display("loader test done");
    stop_test();
  end
endmodule : tb_rscs_strap_config
